// ### logic/spdif_in_port.sv
// serial audio input stage and biphase clock divider
`timescale 1ns/1ns
`default_nettype none
`include "spdif_in_consts.svh"

// ==========================================================
// timing notes
// ==========================================================
// the serial pins are plain samples of clk_sys: each sclk
// level must last one clk_sys cycle or a rise is missed
// a sync transition restarts the bit position, so a word cut
// short by an early transition is dropped, never half sent
// width_sel is read live: change it only between frames
// format code 3 is no framing of its own: i2s offset with
// the left-justified channel polarity
// word_valid follows the rise of the last bit by one cycle
// the oversample clock is sampled the same way and must
// stay below half of clk_sys

module spdif_in_port (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  // configuration levels
  input  wire logic                     fmt_valid,
  input  wire spdif_in_pkg::frame_fmt_t fmt_sel,
  input  wire logic [1:0]               width_sel,
  input  wire logic                     osr_sel,
  // serial pins, sampled as synchronous
  input  wire spdif_in_pkg::serial_in_t ser_in,
  input  wire logic                     oversample_clock,
  // word to the biphase encoder
  output logic                          word_valid,
  output spdif_in_pkg::sample_t         word_out,
  // biphase clock enable pulse
  output logic                          biphase_tick
);
  import spdif_in_pkg::*;

  // ==========================================================
  // configuration
  // ==========================================================
  // fmt_valid is a level: the choice reloads every cycle
  frame_fmt_t fmt_reg;
  wire  frame_fmt_t fmt_next = fmt_valid ? fmt_sel : fmt_reg;

  // hold the format; i2s until a valid choice arrives
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fmt_reg <= FRAME_I2S;
    end else begin
      fmt_reg <= fmt_next;
    end
  end

  // width code decoded once, shared by length and offset
  wire logic w_16 = (width_sel == `WW_16);
  wire logic w_18 = (width_sel == `WW_18);
  wire logic w_20 = (width_sel == `WW_20);

  // word length in bits per width code
  wire logic [5:0] wlen =
    w_16 ? `WLEN_16 :
    w_18 ? `WLEN_18 :
    w_20 ? `WLEN_20 : `WLEN_24;

  // rj puts the lsb just before the next transition
  wire logic [5:0] ofs_rj =
    w_16 ? `OFS_RJ_16 :
    w_18 ? `OFS_RJ_18 :
    w_20 ? `OFS_RJ_20 : `OFS_RJ_24;

  // msb position after a transition for the held framing
  wire logic [5:0] msb_ofs =
    (fmt_reg == FRAME_RJ) ? ofs_rj :
    (fmt_reg == FRAME_LJ) ? `OFS_LJ : `OFS_I2S;

  // ==========================================================
  // serial edge detection
  // ==========================================================
  // reset levels match the idle-low pins, so no false edge
  // appears when reset lets go
  logic sclk_reg;
  logic fs_reg;
  wire  logic sclk_rise = ser_in.sclk & ~sclk_reg;
  // sync sampled at the rising edge, same as data
  wire  logic fs_edge = sclk_rise & (ser_in.fsync != fs_reg);

  // track previous pin levels
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclk_reg <= 1'b0;
      fs_reg   <= 1'b0;
    end else begin
      sclk_reg <= ser_in.sclk;
      fs_reg   <= sclk_rise ? ser_in.fsync : fs_reg;
    end
  end

  // ==========================================================
  // bit counter and shift register
  // ==========================================================
  // count is bit position since the last sync transition;
  // in rj mode the last bit lands right before the next
  // transition only with 64 clocks per frame
  logic [5:0]  cnt_reg;
  logic [23:0] shift_reg;
  logic        chan_reg;
  wire  logic [5:0] cnt_now  = fs_edge ? 6'h00 : cnt_reg;
  wire  logic [5:0] last_bit = msb_ofs + wlen - 6'h01;
  // bits before the offset or past the last bit are ignored
  wire  logic       in_word  = sclk_rise &&
                               (cnt_now >= msb_ofs) &&
                               (cnt_now <= last_bit);
  wire  logic       word_end = sclk_rise && (cnt_now == last_bit);
  // right channel: rj/lj sync low, i2s sync high
  wire  logic       is_right = (fmt_reg == FRAME_I2S) ?
                               ser_in.fsync : ~ser_in.fsync;
  // hold at the top so a link without transitions stays quiet
  wire  logic       cnt_sat  = (cnt_now == `CNT_SAT);
  wire  logic [5:0] cnt_next =
    !sclk_rise ? cnt_reg :
    cnt_sat    ? cnt_now : cnt_now + 6'h01;
  // left shift that puts the word msb at bit 23
  wire  logic [4:0] pad = 5'(`WLEN_24 - wlen);

  // per-bit shift path: bit 0 takes the pin, the rest move up
  wire  logic [23:0] shift_next;
  assign shift_next[0] = in_word ? ser_in.sdata : shift_reg[0];
  for (genvar gi = 1; gi < 24; gi++) begin : g_shift
    assign shift_next[gi] = in_word ? shift_reg[gi - 1] : shift_reg[gi];
  end

  // bit position; saturates so a long frame is harmless
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= `CNT_SAT;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // shift register and channel of the word in progress
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_reg <= 24'h000000;
      chan_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      chan_reg  <= fs_edge ? is_right : chan_reg;
    end
  end

  // ==========================================================
  // word hand-off
  // ==========================================================
  // msb-aligned in 24 bits so the encoder sees one format;
  // the shift also drops stale bits of the previous word
  wire logic [23:0] word_data = shift_next << pad;
  // channel taken at the transition that opened the word
  wire logic        word_chan = fs_edge ? is_right : chan_reg;

  // one pulse per finished channel word
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_valid <= 1'b0;
      word_out   <= '0;
    end else begin
      word_valid <= word_end;
      word_out   <= word_end ? {word_chan, word_data}
                             : word_out;
    end
  end

  // ==========================================================
  // biphase clock divider
  // ==========================================================
  // oversample clock is sampled here, so it must stay below
  // half of clk_sys; one tick every div rising edges
  // both ratios end at 128 ticks per frame: two biphase cells
  // for each of the 64 bit slots
  // the >= compare recovers if osr_sel shrinks mid-count
  logic       osc_reg;
  logic [7:0] div_reg;
  wire  logic       osc_rise  = oversample_clock & ~osc_reg;
  wire  logic [7:0] div_count = (osr_sel == `OSR_384) ?
                                `DIV_384 : `DIV_256;
  wire  logic       div_wrap  = osc_rise &&
                                (div_reg >= div_count - 8'd1);
  wire  logic [7:0] div_next  = div_wrap ? 8'h00 :
                                osc_rise ? div_reg + 8'd1 : div_reg;

  // divide down to the biphase rate
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      osc_reg <= 1'b0;
      div_reg <= 8'h00;
    end else begin
      osc_reg <= oversample_clock;
      div_reg <= div_next;
    end
  end

  // tick registered so the output comes from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      biphase_tick <= 1'b0;
    end else begin
      biphase_tick <= div_wrap;
    end
  end
endmodule
`default_nettype wire

// ### logic/spdif_in_consts.svh
// constants for the serial audio input stage
`ifndef SPDIF_IN_CONSTS_SVH
`define SPDIF_IN_CONSTS_SVH
// framing codes
`define FMT_I2S        2'h0
`define FMT_LJ         2'h1
`define FMT_RJ         2'h2
// word width codes
`define WW_16          2'h0
`define WW_18          2'h1
`define WW_20          2'h2
`define WW_24          2'h3
// msb offsets in serial clocks after a sync transition
`define OFS_I2S        6'h01
`define OFS_LJ         6'h00
`define OFS_RJ_16      6'h10
`define OFS_RJ_18      6'h0E
`define OFS_RJ_20      6'h0C
`define OFS_RJ_24      6'h08
// word lengths in bits per width code
`define WLEN_16        6'h10
`define WLEN_18        6'h12
`define WLEN_20        6'h14
`define WLEN_24        6'h18
// bit position held while no sync transition is seen
`define CNT_SAT        6'h3F
// oversampling ratio codes and biphase divider counts
`define OSR_256        1'h0
`define OSR_384        1'h1
`define DIV_256        8'h02
`define DIV_384        8'h03
`define SAMPLE_W       24
`endif

// ### logic/spdif_in_pkg.sv
// types for the serial audio input stage
package spdif_in_pkg;
  // framing selection
  typedef enum logic [1:0] {
    FRAME_I2S = 2'b00,
    FRAME_LJ  = 2'b01,
    FRAME_RJ  = 2'b10
  } frame_fmt_t;
  // assembled channel word handed downstream
  typedef struct packed {
    logic        right;
    logic [23:0] data;
  } sample_t;
  // serial input pins
  typedef struct packed {
    logic sclk;
    logic fsync;
    logic sdata;
  } serial_in_t;
endpackage

// ### tb/spdif_in_asserts.sv
// checker for the serial audio input stage
`timescale 1ns/1ns
`default_nettype none
module spdif_in_asserts (
  // clock and reset
  input wire logic                     clk_sys,
  input wire logic                     srst,
  // configuration and pins
  input wire logic                     fmt_valid,
  input wire spdif_in_pkg::frame_fmt_t fmt_sel,
  input wire logic [1:0]               width_sel,
  input wire spdif_in_pkg::serial_in_t ser_in,
  input wire logic                     oversample_clock,
  // outputs
  input wire logic                     word_valid,
  input wire spdif_in_pkg::sample_t    word_out,
  input wire logic                     biphase_tick
);
  import spdif_in_pkg::*;
  frame_fmt_t  fmt_reg;
  logic [23:0] low_mask;
  // ==========
  // framing mirror, i2s until loaded
  always_ff @(posedge clk_sys)
    if (srst) fmt_reg <= FRAME_I2S;
    else if (fmt_valid) fmt_reg <= fmt_sel;
  // bits below the word must read zero
  assign low_mask = (width_sel == 2'h0) ? 24'h0000FF :
                    (width_sel == 2'h1) ? 24'h00003F :
                    (width_sel == 2'h2) ? 24'h00000F : 24'h000000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_quiet_w; !word_valid [*3]; endsequence
  sequence s_quiet_t; !biphase_tick [*3]; endsequence
  chk_reset_quiet: assert property (
    $past(srst) |-> !word_valid && !biphase_tick && word_out == '0)
    else $error("outputs busy after reset");
  chk_out_hold: assert property (
    $changed(word_out) |-> word_valid) else $error("word moved alone");
  chk_word_cause: assert property (
    word_valid |-> $past(ser_in.sclk) && !$past(ser_in.sclk, 2))
    else $error("word not after clock rise");
  chk_chan_flag: assert property (
    word_valid |-> word_out.right == ((fmt_reg == FRAME_I2S) ==
    $past(ser_in.fsync))) else $error("channel flag wrong");
  chk_data_low: assert property (
    word_valid |-> (word_out.data & low_mask) == '0)
    else $error("low bits set");
  chk_word_gap: assert property (
    word_valid |=> s_quiet_w) else $error("word pulse too close");
  chk_tick_gap: assert property (
    biphase_tick |=> s_quiet_t) else $error("tick pulse too close");
  chk_tick_idle: assert property (
    biphase_tick |-> $past(oversample_clock) && !$past(oversample_clock, 2))
    else $error("tick without clock rise");
endmodule
bind spdif_in_port spdif_in_asserts spdif_in_asserts_inst (.clk_sys,
  .srst, .fmt_valid, .fmt_sel, .width_sel, .ser_in, .oversample_clock,
  .word_valid, .word_out, .biphase_tick);
`default_nettype wire

// ### tb/serial_src.sv
// serial audio source model: clock, sync, data
`timescale 1ns/1ns
`default_nettype none
module serial_src (
  // pacing clock
  input wire logic                    clk_sys,
  // serial pins
  output var spdif_in_pkg::serial_in_t ser
);
  import spdif_in_pkg::*;
  initial ser = '0;
  // ==========
  // one bit: set while low, held two cycles past the rise
  task automatic bit_out(input logic fs, input logic d);
    @(negedge clk_sys);
    ser = {1'b0, fs, d};
    repeat (2) @(negedge clk_sys);
    ser.sclk = 1'b1;
    @(negedge clk_sys);
  endtask
  // 64 clocks a frame; idle bits toggle, never a clean copy
  task automatic frame(input frame_fmt_t f, input int w,
                       input logic [23:0] l, input logic [23:0] r);
    logic lv;
    int   ofs;
    int   k;
    lv = (f != FRAME_I2S);
    ofs = (f == FRAME_I2S) ? 1 : (f == FRAME_LJ) ? 0 : 32 - w;
    bit_out(!lv, !ser.sdata);
    for (int p = 0; p < 64; p++) begin
      k = p % 32 - ofs;
      bit_out(p < 32 ? lv : !lv, (k >= 0 && k < w) ?
              (p < 32 ? l[23 - k] : r[23 - k]) : !ser.sdata);
    end
    // park the clock low so no rise is left pending
    @(negedge clk_sys);
    ser.sclk = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the serial audio input stage
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import spdif_in_pkg::*;
  logic       clk_sys, srst, fmt_valid, osr_sel, oversample_clock;
  logic       word_valid, biphase_tick;
  logic [1:0] width_sel;
  frame_fmt_t fmt_sel;
  serial_in_t ser_in;
  sample_t    word_out;
  sample_t    got_q[$];
  int         n_mismatch = 0;
  int         tests_run = 0;
  // ==========
  spdif_in_port spdif_in_port_inst (.clk_sys, .srst, .fmt_valid, .fmt_sel,
    .width_sel, .osr_sel, .ser_in, .oversample_clock, .word_valid,
    .word_out, .biphase_tick);
  serial_src serial_src_inst (.clk_sys, .ser(ser_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // capture words at the falling edge, where they are settled
  always @(negedge clk_sys) if (word_valid === 1'b1) got_q.push_back(word_out);
  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one frame, expect left then right word, msb aligned
  task automatic run_frame(input frame_fmt_t f, input logic [1:0] ws);
    logic [23:0] m;
    m = 24'hFFFFFF << (8 - 2 * ws - (ws == 2'h3 ? 2 : 0));
    width_sel = ws;
    got_q.delete();
    serial_src_inst.frame(f, 24 - (8 - 2 * ws - (ws == 2'h3 ? 2 : 0)),
                          24'hA5C396, 24'h5A3C69);
    repeat (4) @(negedge clk_sys);
    check(25'(got_q.size()), 25'h2);
    while (got_q.size() < 2) got_q.push_back('1);
    check(got_q[0], {1'b0, 24'hA5C396 & m});
    check(got_q[1], {1'b1, 24'h5A3C69 & m});
  endtask
  task automatic t_default;
    run_frame(FRAME_I2S, 2'h3);
    $display("default framing done");
  endtask
  task automatic t_formats;
    fmt_valid = 1'b1;
    for (int f = 0; f < 3; f++)
      for (int ws = 0; ws < 4; ws++) begin
        fmt_sel = frame_fmt_t'(f);
        run_frame(fmt_sel, ws[1:0]);
      end
    $display("framings and widths done");
  endtask
  // mid-run reset must fall back to i2s with fmt_valid low
  task automatic t_reset;
    fmt_valid = 1'b0;
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    check(25'(word_valid), 25'h0);
    check(word_out, 25'h0);
    run_frame(FRAME_I2S, 2'h1);
    $display("reset framing done");
  endtask
  // 12 clock periods hold whole tick groups for both ratios
  task automatic t_divider;
    int n;
    for (int o = 0; o < 2; o++) begin
      osr_sel = o[0];
      n = 0;
      for (int i = 0; i < 96; i++) begin
        @(negedge clk_sys);
        oversample_clock = i[1];
        if (i >= 48 && biphase_tick === 1'b1) n++;
      end
      check(25'(n), 25'(12 / (2 + o)));
    end
    repeat (8) @(negedge clk_sys);
    $display("divider done");
  endtask
  initial begin
    srst = 1'b1;
    fmt_valid = 1'b0;
    fmt_sel = FRAME_RJ;
    width_sel = 2'h0;
    osr_sel = 1'b0;
    oversample_clock = 1'b0;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    t_default;
    t_formats;
    t_reset;
    t_divider;
    print_verdict;
  end
endmodule
`default_nettype wire
